// [src/sdcd_pkg.sv]
// Shared constants of the serial display command decoder: byte codes,
// field positions, reset values and timing counts.
// Assumes a single 200 MHz core clock.
package sdcd_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CORE_CLK_MHZ = 200;
  localparam int IDLE_GAP_NS = 40000;
  // Longest time rounded down to whole cycles
  localparam int IDLE_GAP_CYC = (IDLE_GAP_NS * CORE_CLK_MHZ) / 1000;
  localparam int SCAN_REPS = 4;

  ////////////////////////////////////////////////////////////////////////
  // Byte layout
  localparam int BYTE_W = 8;
  localparam int CBIT_POS = 7;
  localparam int GLYPH_W = 6;
  localparam int DUTY_W = 5;
  localparam int POS_W = 4;
  localparam int CNT_W = 5;
  localparam logic [3:0] OP_PTR = 4'ha;
  localparam logic [3:0] OP_CNT = 4'hc;
  localparam logic [2:0] OP_DUTY = 3'h7;

  ////////////////////////////////////////////////////////////////////////
  // Punctuation glyph codes that merge into the previous position
  localparam logic [5:0] GLYPH_DOT = 6'h2e;
  localparam logic [5:0] GLYPH_COMMA = 6'h2c;

  ////////////////////////////////////////////////////////////////////////
  // Reset values and full-scale duty
  localparam logic [4:0] DUTY_RST = 5'h00;
  localparam logic [4:0] CNT_RST = 5'h10;
  localparam logic [3:0] PTR_RST = 4'hf;
  localparam logic [4:0] DUTY_MAX = 5'h1f;

  ////////////////////////////////////////////////////////////////////////
  // Software port map
  localparam int ADDR_W = 5;
  localparam logic [4:0] ADR_PTR = 5'h10;
  localparam logic [4:0] ADR_CNT = 5'h11;
  localparam logic [4:0] ADR_DUTY = 5'h12;
  localparam logic [4:0] ADR_CTRL = 5'h13;
  localparam int CTRL_EN_BIT = 0;
  localparam logic [7:0] CTRL_RST = 8'h01;

endpackage : sdcd_pkg

// [src/sdcd_buf_mem.sv]
// Display buffer: one write port, two read ports with registered data.
// Assumes writes and reads on the same core clock.
`timescale 1ns/100ps
module sdcd_buf_mem
  import sdcd_pkg::*;
#(
  parameter int DW = 6,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [DW-1:0] i_wdata,
  // Read ports
  input wire logic [AW-1:0] i_raddr_a,
  output logic [DW-1:0] o_rdata_a,
  input wire logic [AW-1:0] i_raddr_b,
  output logic [DW-1:0] o_rdata_b
);

  logic [DW-1:0] mem_r [0:(1<<AW)-1];
  logic [DW-1:0] qa_r;
  logic [DW-1:0] qb_r;

  // Array kept without reset so it maps onto plain storage
  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      qa_r <= '0;
      qb_r <= '0;
    end else begin
      qa_r <= mem_r[i_raddr_a];
      qb_r <= mem_r[i_raddr_b];
    end
  end

  assign o_rdata_a = qa_r;
  assign o_rdata_b = qb_r;

endmodule : sdcd_buf_mem

// [src/sdcd_decoder.sv]
// Serial command decoder for a 16-position display: byte receiver,
// control/character decoder, display buffer, scan and luminance gating.
// Assumes link pins are asynchronous and i_arst_n is the module reset pin.
//
// What this block does
// - Byte with top bit set is control, otherwise character.
// - Control upper nibble 1010 loads buffer pointer from lower nibble.
// - Pointer code AF means position 1, A0 position 2, AE position 16.
// - Control upper nibble 1100 loads digit counter from lower nibble, nibble 0 giving 16.
// - Control upper three bits 111 load five-bit luminance duty.
// - Digit on time scales linearly with duty; 31 is full brightness.
// - Duty zero switches all drivers off, blanking the display.
// - Character byte ignores bit 6; bits 5..0 are stored glyph code.
// - Pointer increments before each character is stored.
// - Dot and comma codes merge into previous position, no increment.
// - Reset gives duty 0, digit count 16, pointer at position 1.
// - Bytes arrive MSB first, sampled on falling serial clock edges.
`timescale 1ns/100ps
module sdcd_decoder
  import sdcd_pkg::*;
#(
  parameter int IDLE_CYC = IDLE_GAP_CYC,
  parameter int REPS = SCAN_REPS
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  // Serial link
  input wire logic i_sclk,
  input wire logic i_sdata,
  // Software port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Display drive
  output logic [POS_W-1:0] o_scan_pos,
  output logic [GLYPH_W-1:0] o_scan_glyph,
  output logic o_scan_dot,
  output logic o_scan_comma,
  output logic o_lum_on,
  output logic o_blank,
  output logic [DUTY_W-1:0] o_duty,
  output logic [CNT_W-1:0] o_digit_cnt
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [POS_W-1:0] next_idx(input logic [POS_W-1:0] p);
    next_idx = p + 4'h1;
  endfunction : next_idx

  function automatic logic is_punct(input logic [GLYPH_W-1:0] g);
    is_punct = (g == GLYPH_DOT) || (g == GLYPH_COMMA);
  endfunction : is_punct

  ////////////////////////////////////////////////////////////////////////
  // Link synchronisers and byte receiver
  logic sclk_s1_r, sclk_s2_r, sclk_s3_r;
  logic data_s1_r, data_s2_r;
  logic [7:0] shift_r, shift_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [15:0] idle_r, idle_nxt;
  logic [7:0] byte_r, byte_nxt;
  logic byte_vld_r, byte_vld_nxt;
  logic fall;

  assign fall = sclk_s3_r & ~sclk_s2_r;

  always_comb begin
    shift_nxt = shift_r;
    bit_nxt = bit_r;
    idle_nxt = idle_r;
    byte_nxt = byte_r;
    byte_vld_nxt = 1'b0;
    if (fall) begin
      shift_nxt = {shift_r[6:0], data_s2_r};
      bit_nxt = bit_r + 3'h1;
      idle_nxt = '0;
      if (bit_r == 3'h7) begin
        byte_nxt = {shift_r[6:0], data_s2_r};
        byte_vld_nxt = 1'b1;
        bit_nxt = '0;
      end
    end else if (idle_r < 16'(IDLE_CYC)) begin
      idle_nxt = idle_r + 16'h1;
    end else begin
      // A long quiet line realigns a stray partial byte
      bit_nxt = '0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sclk_s1_r <= 1'b1;
      sclk_s2_r <= 1'b1;
      sclk_s3_r <= 1'b1;
      data_s1_r <= 1'b0;
      data_s2_r <= 1'b0;
      shift_r <= '0;
      bit_r <= '0;
      idle_r <= '0;
      byte_r <= '0;
      byte_vld_r <= 1'b0;
    end else begin
      sclk_s1_r <= i_sclk;
      sclk_s2_r <= sclk_s1_r;
      sclk_s3_r <= sclk_s2_r;
      data_s1_r <= i_sdata;
      data_s2_r <= data_s1_r;
      shift_r <= shift_nxt;
      bit_r <= bit_nxt;
      idle_r <= idle_nxt;
      byte_r <= byte_nxt;
      byte_vld_r <= byte_vld_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Command decode and display state
  logic [POS_W-1:0] ptr_r, ptr_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [DUTY_W-1:0] duty_r, duty_nxt;
  logic [15:0] dot_r, dot_nxt;
  logic [15:0] comma_r, comma_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic we;
  logic [POS_W-1:0] waddr;
  logic [GLYPH_W-1:0] glyph;
  logic take;

  assign take = byte_vld_r & ctrl_r[CTRL_EN_BIT];
  assign glyph = byte_r[GLYPH_W-1:0];

  always_comb begin
    ptr_nxt = ptr_r;
    cnt_nxt = cnt_r;
    duty_nxt = duty_r;
    dot_nxt = dot_r;
    comma_nxt = comma_r;
    we = 1'b0;
    waddr = next_idx(ptr_r);
    if (take && byte_r[CBIT_POS]) begin
      if (byte_r[7:4] == OP_PTR) begin
        // Nibble F leaves the next character at position 1
        ptr_nxt = byte_r[3:0];
      end else if (byte_r[7:4] == OP_CNT) begin
        cnt_nxt = (byte_r[3:0] == 4'h0) ? CNT_RST : {1'b0, byte_r[3:0]};
      end else if (byte_r[7:5] == OP_DUTY) begin
        duty_nxt = byte_r[DUTY_W-1:0];
      end
      // Other control patterns fall through untouched
    end else if (take) begin
      if (is_punct(glyph)) begin
        // Punctuation rides on the last written position
        dot_nxt[ptr_r] = dot_r[ptr_r] | (glyph == GLYPH_DOT);
        comma_nxt[ptr_r] = comma_r[ptr_r] | (glyph == GLYPH_COMMA);
      end else begin
        we = 1'b1;
        ptr_nxt = next_idx(ptr_r);
        dot_nxt[waddr] = 1'b0;
        comma_nxt[waddr] = 1'b0;
      end
    end
    if (i_wr && i_addr == ADR_CTRL) begin
      ctrl_nxt = i_wdata;
    end else begin
      ctrl_nxt = ctrl_r;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ptr_r <= PTR_RST;
      cnt_r <= CNT_RST;
      duty_r <= DUTY_RST;
      dot_r <= '0;
      comma_r <= '0;
      ctrl_r <= CTRL_RST;
    end else begin
      ptr_r <= ptr_nxt;
      cnt_r <= cnt_nxt;
      duty_r <= duty_nxt;
      dot_r <= dot_nxt;
      comma_r <= comma_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Display buffer
  logic [POS_W-1:0] pos_r, pos_nxt;
  logic [GLYPH_W-1:0] scan_q;
  logic [GLYPH_W-1:0] bus_q;

  sdcd_buf_mem #(
    .DW(GLYPH_W),
    .AW(POS_W)
  ) u_buf (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_we(we),
    .i_waddr(waddr),
    .i_wdata(glyph),
    .i_raddr_a(pos_r),
    .o_rdata_a(scan_q),
    .i_raddr_b(i_addr[POS_W-1:0]),
    .o_rdata_b(bus_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Scan and luminance gating
  // Phase runs 0..30 so on time is duty/31 of each digit slot
  logic [DUTY_W-1:0] phase_r, phase_nxt;
  logic [7:0] rep_r, rep_nxt;
  logic [POS_W-1:0] spos_r, spos_nxt;
  logic sdot_r, sdot_nxt;
  logic scomma_r, scomma_nxt;
  logic lum_r, lum_nxt;

  always_comb begin
    phase_nxt = phase_r + 5'h1;
    rep_nxt = rep_r;
    pos_nxt = pos_r;
    if (phase_r == DUTY_MAX - 5'h1) begin
      phase_nxt = '0;
      rep_nxt = rep_r + 8'h1;
      if (rep_r == 8'(REPS - 1)) begin
        rep_nxt = '0;
        // Only the positions in the digit count are scanned
        if ({1'b0, pos_r} + 5'h1 >= cnt_r) begin
          pos_nxt = '0;
        end else begin
          pos_nxt = next_idx(pos_r);
        end
      end
    end
    if ({1'b0, pos_r} >= cnt_r) begin
      pos_nxt = '0;
    end
    spos_nxt = pos_r;
    sdot_nxt = dot_r[pos_r];
    scomma_nxt = comma_r[pos_r];
    // Gate from next values so the drive drops in the same cycle duty reaches zero
    lum_nxt = (duty_nxt != DUTY_RST) && (phase_nxt < duty_nxt);
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      phase_r <= '0;
      rep_r <= '0;
      pos_r <= '0;
      spos_r <= '0;
      sdot_r <= 1'b0;
      scomma_r <= 1'b0;
      lum_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      rep_r <= rep_nxt;
      pos_r <= pos_nxt;
      spos_r <= spos_nxt;
      sdot_r <= sdot_nxt;
      scomma_r <= scomma_nxt;
      lum_r <= lum_nxt;
    end
  end

  assign o_scan_pos = spos_r;
  assign o_scan_glyph = scan_q;
  assign o_scan_dot = sdot_r;
  assign o_scan_comma = scomma_r;
  assign o_lum_on = lum_r;
  assign o_blank = (duty_r == DUTY_RST);
  assign o_duty = duty_r;
  assign o_digit_cnt = cnt_r;

  ////////////////////////////////////////////////////////////////////////
  // Software read path
  // Buffer glyph bits come from the memory register, their dot/comma flags and the rest from stat_r
  logic [7:0] stat_r, stat_nxt;
  logic sel_mem_r, sel_mem_nxt;

  always_comb begin
    stat_nxt = '0;
    sel_mem_nxt = 1'b0;
    if (i_rd) begin
      if (i_addr[ADDR_W-1] == 1'b0) begin
        sel_mem_nxt = 1'b1;
        stat_nxt = {comma_r[i_addr[POS_W-1:0]], dot_r[i_addr[POS_W-1:0]], 6'h00};
      end else begin
        case (i_addr)
          ADR_PTR: stat_nxt = {4'h0, ptr_r};
          ADR_CNT: stat_nxt = {3'h0, cnt_r};
          ADR_DUTY: stat_nxt = {3'h0, duty_r};
          ADR_CTRL: stat_nxt = ctrl_r;
          default: stat_nxt = '0;
        endcase
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stat_r <= '0;
      sel_mem_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      sel_mem_r <= sel_mem_nxt;
    end
  end

  assign o_rdata = sel_mem_r ? (stat_r | {2'h0, bus_q}) : stat_r;

endmodule : sdcd_decoder

// [dv/sdcd_decoder_chk.sv]
// Port checker of the serial display command decoder.
// Bound to every sdcd_decoder; sees its ports only, one core clock.
`timescale 1ns/100ps
module sdcd_decoder_chk
  import sdcd_pkg::*;
(
  // Clock, reset and link
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_sclk,
  // Software port
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // Display drive
  input wire logic o_lum_on,
  input wire logic o_blank,
  input wire logic [DUTY_W-1:0] o_duty,
  input wire logic [CNT_W-1:0] o_digit_cnt
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);

  ////////////////////////////////////////////////////////////////////////
  blank_tracks_a: assert property (o_blank == (o_duty == 5'h00))
    else $error("blank flag disagrees with duty");
  blank_dark_a: assert property (o_blank |-> !o_lum_on)
    else $error("segments driven while blank");
  full_lum_a: assert property ((o_duty == DUTY_MAX) [*3] |-> o_lum_on)
    else $error("full duty not always on");
  min_lum_a: assert property (o_lum_on && o_duty == 5'h01 && $stable(o_duty) |=> !o_lum_on)
    else $error("duty one on longer than a cycle");
  cnt_range_a: assert property (o_digit_cnt != 5'h00 && o_digit_cnt <= 5'h10)
    else $error("digit count out of range");
  rd_duty_a: assert property (i_rd && i_addr == ADR_DUTY |=> o_rdata == {3'h0, $past(o_duty)})
    else $error("duty read back wrong");
  rd_count_a: assert property (i_rd && i_addr == ADR_CNT |=> o_rdata == {3'h0, $past(o_digit_cnt)})
    else $error("count read back wrong");
  // Latency of the link path is under eight cycles, so a long high clock means settled state
  link_quiet_a: assert property (i_sclk [*8] |-> $stable(o_duty) && $stable(o_digit_cnt))
    else $error("state moved without link activity");

  ////////////////////////////////////////////////////////////////////////
  cover property (i_rd && i_addr == ADR_DUTY);
  cover property (o_duty == DUTY_MAX [*4]);
  cover property ($fell(o_blank));
endmodule : sdcd_decoder_chk

bind sdcd_decoder sdcd_decoder_chk chk_u (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
  .i_sclk(i_sclk), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .o_lum_on(o_lum_on),
  .o_blank(o_blank), .o_duty(o_duty), .o_digit_cnt(o_digit_cnt));

// [dv/sdcd_host.sv]
// Host model of the serial link: shift clock and data line.
// Clock idles high; outside frames the data line shows a changed level.
`timescale 1ns/100ps
module sdcd_host #(
  parameter int GAP_NS = 40000
) (
  // Link outputs
  output logic o_sclk,
  output logic o_sdata
);
  initial begin
    o_sclk = 1'b1;
    o_sdata = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      o_sdata = b[i];
      #62.5 o_sclk = 1'b0;
      #62.5 o_sclk = 1'b1;
    end
    #62.5 o_sdata = ~o_sdata;
    // Gap is a parameter so the bench can shorten it for run time
    #(GAP_NS);
  endtask : send
endmodule : sdcd_host

// [dv/tb.sv]
// Self-checking bench of the decoder: bytes from the host model,
// state read back over the software port.
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
  $display("BAD %0t got %h want %h", $time, g, e); end end
module tb;
  import sdcd_pkg::*;
  logic clk = 1'b0;
  logic rst_n;
  logic sclk, sdata, lum, blank;
  logic wr;
  logic rd;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic [3:0] pscan;
  logic [5:0] gscan;
  logic dscan, cscan;
  logic [7:0] rdata;
  logic [4:0] duty, cnt;
  logic [7:0] ign [4] = '{8'h80, 8'h9f, 8'hb3, 8'hd5};
  logic [4:0] dv [4] = '{5'h18, 5'h01, 5'h1f, 5'h00};
  int errors = 0;
  int compares = 0;

  always #2.5 clk = ~clk;

  sdcd_host #(.GAP_NS(2000)) host_u (.o_sclk(sclk), .o_sdata(sdata));
  sdcd_decoder #(.IDLE_CYC(200), .REPS(1)) dut_u (.i_core_clk(clk), .i_arst_n(rst_n),
    .i_sclk(sclk), .i_sdata(sdata), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_scan_pos(pscan), .o_scan_glyph(gscan), .o_scan_dot(dscan),
    .o_scan_comma(cscan),
    .o_lum_on(lum), .o_blank(blank), .o_duty(duty), .o_digit_cnt(cnt));

  ////////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic chk_rd(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : chk_rd

  task automatic chk_lum(input int e);
    int n;
    n = 0;
    repeat (310) begin
      @(posedge clk);
      #1 if (lum === 1'b1) n++;
    end
    `CHK(n, e)
  endtask : chk_lum

  task automatic stop_test();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n <= 1'b0;
    wr <= 1'b0;
    rd <= 1'b0;
    addr <= 5'h00;
    wdata <= 8'h00;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20000) @(posedge clk);
    chk_rd(ADR_DUTY, 8'h00);
    chk_rd(ADR_CNT, 8'h10);
    chk_rd(ADR_PTR, 8'h0f);
    `CHK(blank, 1'b1)
    host_u.send(8'h41);
    chk_rd(5'h00, 8'h01);
    host_u.send(8'h2e);
    chk_rd(5'h00, 8'h41);
    host_u.send(8'h2c);
    chk_rd(5'h00, 8'hc1);
    chk_rd(ADR_PTR, 8'h00);
    host_u.send(8'hae);
    host_u.send(8'h15);
    host_u.send(8'h7f);
    chk_rd(5'h0f, 8'h15);
    chk_rd(5'h00, 8'h3f);
    host_u.send(8'ha5);
    host_u.send(8'h2a);
    chk_rd(5'h06, 8'h2a);
    host_u.send(8'hc6);
    chk_rd(ADR_CNT, 8'h06);
    host_u.send(8'hc0);
    chk_rd(ADR_CNT, 8'h10);
    foreach (ign[i]) host_u.send(ign[i]);
    chk_rd(ADR_PTR, 8'h06);
    chk_rd(ADR_DUTY, 8'h00);
    wr_reg(ADR_CTRL, 8'h00);
    chk_rd(ADR_CTRL, 8'h00);
    host_u.send(8'hc3);
    chk_rd(ADR_CNT, 8'h10);
    wr_reg(ADR_CTRL, 8'h01);
    wr_reg(ADR_DUTY, 8'h1f);
    chk_rd(ADR_DUTY, 8'h00);
    chk_rd(5'h1f, 8'h00);
    foreach (dv[i]) begin
      host_u.send({3'h7, dv[i]});
      chk_rd(ADR_DUTY, {3'h0, dv[i]});
      chk_lum(10 * int'(dv[i]));
    end
    host_u.send(8'ha0);
    host_u.send(8'h2c);
    host_u.send(8'hc1);
    repeat (40) @(posedge clk);
    #1 `CHK({pscan, gscan, dscan, cscan}, {4'h0, 6'h3f, 1'b0, 1'b1})
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (20000) @(posedge clk);
    chk_rd(ADR_CNT, 8'h10);
    chk_rd(ADR_PTR, 8'h0f);
    `CHK(blank, 1'b1)
    stop_test();
  end

  initial begin
    #400us;
    errors++;
    stop_test();
  end
endmodule : tb
